// >>> design/power_mode_controller.sv
// Global power mode controller: mode state, per-mode clock templates, wakeup.
// Assumes APB from the processor side and asynchronous wake/reset event pins.
//
// Behaviour
// - Four modes: active, alternate active, sleep, hibernate, highest power first.
// - Each subsystem is switched by its own bit in a per-mode template.
// - In active mode the active template chooses the enabled resources.
// - A subsystem disabled by its template has its digital clock gated off.
// - Template writes take effect at once while running.
// - The processor may switch itself off; the next wakeup turns it on.
// - Any wakeup forces active mode and the processor on, whatever the template.
// - Active mode is the mode after reset.
// - Alternate active mode uses its own, usually smaller, template.
// - Sleep disables the subsystems regardless of the templates.
// - Sleep keeps the low-speed clocks, wake counter and real-time clock running.
// - Sleep and hibernate start only by register write and disable all subsystems.
// - Hibernate stops all clocks, keeps state, wakes only from pin events.
// - Hibernate turns off every regulator except the retention regulator.
// - Interrupt wake sources are selectable, reset sources always wake; each restores active mode.
// - Sleep resume completes within 15 us, letting regulators settle first; the resume state here lasts 601 cycles, 15.025 us.
// - Hibernate resume only on pin interrupt or external reset, completing below 100 us; the resume state here lasts 4000 cycles, 100 us.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   // APB slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [7:0]            paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // Wake and reset event pins
   input  wire logic [NUM_WAKE-1:0]   wake_src_i,
   // Power control outputs
   output pwr_ctl_t                   pwr_ctl_o,
   output pwr_mode_t                  mode_o
);

   // ==========================================================================
   // State
   typedef struct packed {
      pwr_mode_t             mode;
      logic [NUM_SUBSYS-1:0] act_tpl;
      logic [NUM_SUBSYS-1:0] alt_tpl;
      logic [NUM_WAKE-1:0]   wake_en;
      logic [NUM_WAKE-1:0]   wake_cause;
      logic [NUM_WAKE-1:0]   wake_prev;
      pwr_ctl_t              ctl;
      logic [31:0]           rdata;
      logic                  slverr;
   } ctl_st_t;

   ctl_st_t st;
   ctl_st_t next_st;

   logic [NUM_WAKE-1:0] wake_sync;
   logic [NUM_WAKE-1:0] wake_rise;
   logic [NUM_WAKE-1:0] wake_armed;
   logic [NUM_WAKE-1:0] wake_allowed;
   logic                wake_hit;
   logic                tmr_start;
   logic [CNT_W-1:0]    tmr_len;
   logic                tmr_busy;
   logic                tmr_done;
   logic                setup_phase;
   logic                access_phase;
   logic                addr_mapped;
   logic [31:0]         rd_mux;

   // ==========================================================================
   // Submodules
   // The wake pins are asynchronous to the bus clock, hence two stages first.
   pin_sync #(
      .W (NUM_WAKE)
   ) u_wake_sync (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .async_i  (wake_src_i),
      .sync_o   (wake_sync)
   );

   resume_timer u_resume_timer (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .start_i  (tmr_start),
      .len_i    (tmr_len),
      .busy_o   (tmr_busy),
      .done_o   (tmr_done)
   );

   // ==========================================================================
   // APB decode
   // Zero wait states: every access completes in its first access cycle.
   assign setup_phase  = psel_i & ~penable_i;
   assign access_phase = psel_i & penable_i;
   assign pready_o     = access_phase;
   assign prdata_o     = st.rdata;
   assign pslverr_o    = access_phase & st.slverr;

   always_comb begin
      addr_mapped = 1'b1;
      rd_mux      = 32'h0000_0000;
      case (paddr_i)
         MODE_CTRL_ADDR: begin
            rd_mux[2:0] = st.mode;
         end
         ACT_TPL_ADDR: begin
            rd_mux[NUM_SUBSYS-1:0] = st.act_tpl;
         end
         ALT_TPL_ADDR: begin
            rd_mux[NUM_SUBSYS-1:0] = st.alt_tpl;
         end
         WAKE_EN_ADDR: begin
            rd_mux[NUM_WAKE-1:0] = st.wake_en;
         end
         PWR_STATUS_ADDR: begin
            rd_mux[ST_MODE_LSB +: 3]             = st.mode;
            rd_mux[ST_BUSY_BIT]                  = tmr_busy;
            rd_mux[ST_CAUSE_LSB +: NUM_WAKE]     = st.wake_cause;
         end
         default: begin
            addr_mapped = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // Wake qualification
   // Events are rising edges of the synchronised level, so a held pin
   // causes one wakeup, not a loop of them.
   assign wake_rise  = wake_sync & ~st.wake_prev;
   // Reset sources cannot be masked off.
   assign wake_armed = wake_rise & (st.wake_en | RESET_WAKE_MASK);

   always_comb begin
      case (st.mode)
         MODE_HIB: begin
            wake_allowed = wake_armed & HIB_WAKE_MASK;
         end
         MODE_RESUME: begin
            wake_allowed = '0;
         end
         default: begin
            wake_allowed = wake_armed;
         end
      endcase
   end

   assign wake_hit = |wake_allowed;

   // ==========================================================================
   // Mode machine and registers
   always_comb begin
      next_st           = st;
      next_st.wake_prev = wake_sync;
      tmr_start         = 1'b0;
      tmr_len           = SLEEP_RESUME_CYC;

      // Read data and error are captured in the setup cycle.
      if (setup_phase) begin
         next_st.rdata  = pwrite_i ? 32'h0000_0000 : rd_mux;
         next_st.slverr = ~addr_mapped;
      end

      // Register writes land at the access edge.
      if (access_phase && pwrite_i) begin
         case (paddr_i)
            ACT_TPL_ADDR: begin
               next_st.act_tpl = pwdata_i[NUM_SUBSYS-1:0];
            end
            ALT_TPL_ADDR: begin
               next_st.alt_tpl = pwdata_i[NUM_SUBSYS-1:0];
            end
            WAKE_EN_ADDR: begin
               next_st.wake_en = pwdata_i[NUM_WAKE-1:0];
            end
            MODE_CTRL_ADDR: begin
               // Low power modes are only reachable from a running mode.
               if (st.mode == MODE_ACTIVE || st.mode == MODE_ALT) begin
                  case (pwdata_i[2:0])
                     MODE_ACTIVE: next_st.mode = MODE_ACTIVE;
                     MODE_ALT:    next_st.mode = MODE_ALT;
                     MODE_SLEEP:  next_st.mode = MODE_SLEEP;
                     MODE_HIB:    next_st.mode = MODE_HIB;
                     default:     next_st.mode = st.mode;
                  endcase
               end
            end
            default: begin
               next_st.mode = next_st.mode;
            end
         endcase
      end

      // A wakeup overrides a write in the same cycle, so it is never lost.
      if (wake_hit) begin
         next_st.wake_cause = wake_allowed;
         next_st.act_tpl[CPU_BIT] = 1'b1;
         case (st.mode)
            MODE_SLEEP: begin
               next_st.mode = MODE_RESUME;
               tmr_start    = 1'b1;
               tmr_len      = SLEEP_RESUME_CYC;
            end
            MODE_HIB: begin
               next_st.mode = MODE_RESUME;
               tmr_start    = 1'b1;
               tmr_len      = HIB_RESUME_CYC;
            end
            default: begin
               next_st.mode = MODE_ACTIVE;
            end
         endcase
      end else if (st.mode == MODE_RESUME && tmr_done) begin
         next_st.mode = MODE_ACTIVE;
      end

      // Outputs follow the next mode so a change shows at the same edge as the mode.
      next_st.ctl.hib_reg_en = 1'b1;
      case (next_st.mode)
         MODE_ACTIVE: begin
            next_st.ctl.subsys_clk_en    = next_st.act_tpl;
            next_st.ctl.low_speed_osc_en = 1'b1;
            next_st.ctl.wake_counter_run = 1'b1;
            next_st.ctl.rtc_run          = 1'b1;
            next_st.ctl.main_reg_en      = 1'b1;
            next_st.ctl.sleep_reg_buzz   = 1'b0;
         end
         MODE_ALT: begin
            next_st.ctl.subsys_clk_en    = next_st.alt_tpl;
            next_st.ctl.low_speed_osc_en = 1'b1;
            next_st.ctl.wake_counter_run = 1'b1;
            next_st.ctl.rtc_run          = 1'b1;
            next_st.ctl.main_reg_en      = 1'b1;
            next_st.ctl.sleep_reg_buzz   = 1'b0;
         end
         MODE_SLEEP: begin
            next_st.ctl.subsys_clk_en    = '0;
            next_st.ctl.low_speed_osc_en = 1'b1;
            next_st.ctl.wake_counter_run = 1'b1;
            next_st.ctl.rtc_run          = 1'b1;
            next_st.ctl.main_reg_en      = 1'b0;
            next_st.ctl.sleep_reg_buzz   = 1'b1;
         end
         MODE_HIB: begin
            next_st.ctl.subsys_clk_en    = '0;
            next_st.ctl.low_speed_osc_en = 1'b0;
            next_st.ctl.wake_counter_run = 1'b0;
            next_st.ctl.rtc_run          = 1'b0;
            next_st.ctl.main_reg_en      = 1'b0;
            next_st.ctl.sleep_reg_buzz   = 1'b0;
         end
         default: begin
            // Resume: regulators come up while subsystems stay gated.
            next_st.ctl.subsys_clk_en    = '0;
            next_st.ctl.low_speed_osc_en = 1'b1;
            next_st.ctl.wake_counter_run = 1'b1;
            next_st.ctl.rtc_run          = 1'b1;
            next_st.ctl.main_reg_en      = 1'b1;
            next_st.ctl.sleep_reg_buzz   = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // State register
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st.mode                 <= MODE_ACTIVE;
         st.act_tpl              <= ACT_TPL_RST;
         st.alt_tpl              <= ALT_TPL_RST;
         st.wake_en              <= WAKE_EN_RST;
         st.wake_cause           <= '0;
         st.wake_prev            <= '0;
         st.ctl.subsys_clk_en    <= ACT_TPL_RST;
         st.ctl.low_speed_osc_en <= 1'b1;
         st.ctl.wake_counter_run <= 1'b1;
         st.ctl.rtc_run          <= 1'b1;
         st.ctl.main_reg_en      <= 1'b1;
         st.ctl.sleep_reg_buzz   <= 1'b0;
         st.ctl.hib_reg_en       <= 1'b1;
         st.rdata                <= 32'h0000_0000;
         st.slverr               <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign pwr_ctl_o = st.ctl;
   assign mode_o    = st.mode;
endmodule
`default_nettype wire

// >>> design/pwr_mode_pkg.sv
// Constants, types and register map of the global power mode controller.
// Assumes a single 40 MHz clock domain and an APB register port.
package pwr_mode_pkg;

   // ==========================================================================
   // Sizes
   localparam int unsigned NUM_SUBSYS = 8;
   localparam int unsigned NUM_WAKE   = 9;
   localparam int unsigned CNT_W      = 12;

   // ==========================================================================
   // Register map, byte offsets on APB
   localparam logic [7:0] MODE_CTRL_ADDR  = 8'h00;
   localparam logic [7:0] ACT_TPL_ADDR    = 8'h04;
   localparam logic [7:0] ALT_TPL_ADDR    = 8'h08;
   localparam logic [7:0] WAKE_EN_ADDR    = 8'h0C;
   localparam logic [7:0] PWR_STATUS_ADDR = 8'h10;

   // Status fields.
   localparam int unsigned ST_MODE_LSB  = 0;
   localparam int unsigned ST_BUSY_BIT  = 4;
   localparam int unsigned ST_CAUSE_LSB = 8;

   // Reset values.
   localparam logic [NUM_SUBSYS-1:0] ACT_TPL_RST = 8'hFF;
   localparam logic [NUM_SUBSYS-1:0] ALT_TPL_RST = 8'h00;
   localparam logic [NUM_WAKE-1:0]   WAKE_EN_RST = 9'h1_FF;

   // Subsystem bit positions inside a template.
   localparam int unsigned CPU_BIT   = 0;
   localparam int unsigned FLASH_BIT = 1;

   // Wake source positions: interrupt-like sources, then reset sources.
   localparam int unsigned WK_PIN_IRQ   = 0;
   localparam int unsigned WK_WAKE_CNT  = 1;
   localparam int unsigned WK_RTC       = 2;
   localparam int unsigned WK_LOW_SUPPLY = 3;
   localparam int unsigned WK_COMPARATOR = 4;
   localparam int unsigned WK_I2C       = 5;
   localparam int unsigned WK_OTHER_IRQ = 6;
   localparam int unsigned WK_EXT_RESET = 7;
   localparam int unsigned WK_WATCHDOG  = 8;

   // Sources that may end hibernate; everything else is ignored there.
   localparam logic [NUM_WAKE-1:0] HIB_WAKE_MASK = 9'h0_81;
   // Reset sources always wake, independent of the enable register.
   localparam logic [NUM_WAKE-1:0] RESET_WAKE_MASK = 9'h1_80;

   // ==========================================================================
   // Resume timing
   localparam int unsigned MCLK_MHZ         = 40;
   localparam int unsigned SLEEP_RESUME_US  = 15;
   localparam int unsigned HIB_RESUME_US    = 100;
   // Longest times round down; hibernate must finish strictly below its limit.
   localparam logic [CNT_W-1:0] SLEEP_RESUME_CYC = CNT_W'(SLEEP_RESUME_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] HIB_RESUME_CYC   = CNT_W'(HIB_RESUME_US * MCLK_MHZ - 1);

   // ==========================================================================
   // Types
   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'b000,
      MODE_ALT    = 3'b001,
      MODE_SLEEP  = 3'b010,
      MODE_HIB    = 3'b011,
      MODE_RESUME = 3'b100
   } pwr_mode_t;

   typedef struct packed {
      logic [NUM_SUBSYS-1:0] subsys_clk_en;
      logic                  low_speed_osc_en;
      logic                  wake_counter_run;
      logic                  rtc_run;
      logic                  main_reg_en;
      logic                  sleep_reg_buzz;
      logic                  hib_reg_en;
   } pwr_ctl_t;

endpackage

// >>> design/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin-level inputs.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_st_t;

   sync_st_t st;
   sync_st_t next_st;

   // ==========================================================================
   // Per-bit stages
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         next_st.meta[i]   = async_i[i];
         next_st.stable[i] = st.meta[i];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_o = st.stable;
endmodule
`default_nettype wire

// >>> design/resume_timer.sv
// Down-counter that times the regulator settling before active mode returns.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module resume_timer
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   // Control
   input  wire logic             start_i,
   input  wire logic [CNT_W-1:0] len_i,
   output logic                  busy_o,
   output logic                  done_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             busy;
      logic             done;
   } tmr_st_t;

   tmr_st_t st;
   tmr_st_t next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (start_i) begin
         next_st.cnt  = len_i;
         next_st.busy = 1'b1;
      end else if (st.busy) begin
         if (st.cnt <= CNT_W'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy_o = st.busy;
   assign done_o = st.done;
endmodule
`default_nettype wire

// >>> verification/power_mode_controller_chk.sv
// Assertion checker for the power mode controller, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_chk
   import pwr_mode_pkg::*;
(
   // Clock and reset
   input wire logic                mclk_i,
   input wire logic                resetn_i,
   // APB
   input wire logic                psel_i,
   input wire logic                penable_i,
   input wire logic                pwrite_i,
   input wire logic [7:0]          paddr_i,
   input wire logic [31:0]         pwdata_i,
   input wire logic [31:0]         prdata_o,
   input wire logic                pready_o,
   input wire logic                pslverr_o,
   // Wake pins and power outputs
   input wire logic [NUM_WAKE-1:0] wake_src_i,
   input wire pwr_ctl_t            pwr_ctl_o,
   input wire pwr_mode_t           mode_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   // ==========================================================================
   // Helpers
   logic [11:0] res_cnt;
   logic        from_hib;
   logic        wr;
   logic [2:0]  wmode;
   logic [7:1]  wtpl;
   assign wr    = psel_i && penable_i && pwrite_i;
   assign wmode = pwdata_i[2:0];
   assign wtpl  = pwdata_i[7:1];

   // The resume length is only known from where the resume started.
   always_ff @(posedge mclk_i) begin
      if (!resetn_i || mode_o != MODE_RESUME) begin
         res_cnt <= 12'h000;
      end else begin
         res_cnt <= res_cnt + 12'h001;
      end
      from_hib <= resetn_i && (mode_o == MODE_HIB || (from_hib && mode_o != MODE_SLEEP));
   end

   // ==========================================================================
   // Assertions
   a_boot_active: assert property (!$past(resetn_i) |->
      mode_o == MODE_ACTIVE && pwr_ctl_o.subsys_clk_en == 8'hFF) else $error("not active after reset");
   a_sleep_gated: assert property (mode_o == MODE_SLEEP |->
      pwr_ctl_o.subsys_clk_en == 8'h00 && !pwr_ctl_o.main_reg_en && pwr_ctl_o.sleep_reg_buzz)
      else $error("sleep leaves a subsystem on");
   a_sleep_timers: assert property (mode_o == MODE_SLEEP |->
      pwr_ctl_o.low_speed_osc_en && pwr_ctl_o.wake_counter_run && pwr_ctl_o.rtc_run)
      else $error("sleep stopped the timers");
   a_hib_retention: assert property (mode_o == MODE_HIB |->
      pwr_ctl_o == pwr_ctl_t'(14'h0001)) else $error("hibernate outputs wrong");
   a_hib_pin_only: assert property (
      (mode_o == MODE_HIB && (wake_src_i & HIB_WAKE_MASK) == 9'h000) [*6] |=> mode_o == MODE_HIB)
      else $error("hibernate left without pin event");
   a_mode_refused: assert property (wr && paddr_i == MODE_CTRL_ADDR &&
      (mode_o == MODE_SLEEP || mode_o == MODE_HIB) |=> mode_o == $past(mode_o) || mode_o == MODE_RESUME)
      else $error("mode write accepted in low power");
   a_mode_taken: assert property (wr && paddr_i == MODE_CTRL_ADDR && wmode < 3'b100 &&
      (mode_o == MODE_ACTIVE || mode_o == MODE_ALT) |=> mode_o == pwr_mode_t'($past(wmode)))
      else $error("mode write not applied");
   a_tpl_live: assert property (wr && (mode_o == MODE_ACTIVE && paddr_i == ACT_TPL_ADDR ||
      mode_o == MODE_ALT && paddr_i == ALT_TPL_ADDR) |=> pwr_ctl_o.subsys_clk_en[7:1] == $past(wtpl))
      else $error("template write not applied");
   a_sleep_resume: assert property (mode_o == MODE_RESUME && !from_hib |-> res_cnt < 12'h259)
      else $error("sleep resume too long");
   a_hib_resume: assert property (mode_o == MODE_RESUME && from_hib |-> res_cnt < 12'hFA0)
      else $error("hibernate resume too long");
   a_resume_exit: assert property ($past(mode_o) == MODE_RESUME && mode_o != MODE_RESUME |->
      mode_o == MODE_ACTIVE && pwr_ctl_o.subsys_clk_en[CPU_BIT]) else $error("resume exit wrong");

   c_sleep: cover property (mode_o == MODE_SLEEP);
   c_hib: cover property (mode_o == MODE_HIB);
   c_resume_exit: cover property ($past(mode_o) == MODE_RESUME && mode_o == MODE_ACTIVE);
endmodule

bind power_mode_controller power_mode_controller_chk power_mode_controller_chk_i (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .wake_src_i(wake_src_i),
   .pwr_ctl_o(pwr_ctl_o), .mode_o(mode_o));
`default_nettype wire

// >>> verification/test_power_mode_controller.sv
// Self-checking testbench for the power mode controller.
// Assumes the checker file is compiled beside it and binds itself.
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller
   import pwr_mode_pkg::*;
;
   logic                mclk     = 1'b0;
   logic                resetn   = 1'b0;
   logic                psel     = 1'b0;
   logic                penable  = 1'b0;
   logic                pwrite   = 1'b0;
   logic [7:0]          paddr    = 8'h00;
   logic [31:0]         pwdata   = 32'h0000_0000;
   logic [NUM_WAKE-1:0] wake_src = 9'h000;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   pwr_ctl_t            pwr_ctl;
   pwr_mode_t           mode;
   logic [31:0]         rd;
   logic                err;
   int                  failures    = 0;
   int                  checks_done = 0;
   logic [31:0]         rst_tbl [5] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0000,
                                        32'h0000_01FF, 32'h0000_0000};

   always #12.5 mclk = ~mclk;

   power_mode_controller power_mode_controller_i (
      .mclk_i(mclk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .wake_src_i(wake_src),
      .pwr_ctl_o(pwr_ctl), .mode_o(mode));

   // ==========================================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; the request stands until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
      if (k >= 16) begin
         failures++;
         conclude();
      end
   endtask

   task automatic wait_mode(input pwr_mode_t m, input int lim);
      int n = 0;
      while (mode !== m && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check(32'(mode), 32'(m));
   endtask

   // The pin is held for several edges so the synchroniser sees it.
   task automatic pulse(input int b);
      @(posedge mclk);
      wake_src[b] <= 1'b1;
      repeat (4) @(posedge mclk);
      wake_src[b] <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
   endtask

   // ==========================================================================
   // Tests
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      check(32'(mode), 32'(MODE_ACTIVE));
      check(32'(pwr_ctl), 32'h0000_3FFD);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0000_0000);
         check(rd, rst_tbl[i]);
      end
      apb(1'b0, 8'h14, 32'h0000_0000);
      check({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, PWR_STATUS_ADDR, 32'h0000_0003);
      apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0004);
      check(32'(mode), 32'(MODE_ACTIVE));
      apb(1'b1, ACT_TPL_ADDR, 32'h0000_005A);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_005A);
      apb(1'b1, ACT_TPL_ADDR, 32'h0000_00A6);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00A6);
      pulse(WK_PIN_IRQ);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00A7);
      apb(1'b1, WAKE_EN_ADDR, 32'h0000_0000);
      apb(1'b1, ACT_TPL_ADDR, 32'h0000_00A6);
      pulse(WK_RTC);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00A6);
      pulse(WK_WATCHDOG);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00A7);
      apb(1'b1, WAKE_EN_ADDR, 32'h0000_01FF);
      apb(1'b1, ALT_TPL_ADDR, 32'h0000_000C);
      apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0001);
      check(32'(mode), 32'(MODE_ALT));
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_000C);
      apb(1'b1, ALT_TPL_ADDR, 32'h0000_0006);
      apb(1'b1, ACT_TPL_ADDR, 32'h0000_00F0);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_0006);
      pulse(WK_OTHER_IRQ);
      wait_mode(MODE_ACTIVE, 8);
      check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00F1);
      for (int b = 0; b < 9; b++) begin
         apb(1'b1, ACT_TPL_ADDR, 32'h0000_00F0);
         apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0002);
         check(32'(pwr_ctl[13:1]), 32'h0000_001D);
         apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0000);
         check(32'(mode), 32'(MODE_SLEEP));
         pulse(b);
         apb(1'b0, PWR_STATUS_ADDR, 32'h0000_0000);
         check(rd, 32'h0000_0014 | (32'h0000_0100 << b));
         wait_mode(MODE_ACTIVE, 600);
         check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00F1);
      end
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, ACT_TPL_ADDR, 32'h0000_00F0);
         apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0003);
         check(32'(pwr_ctl), 32'h0000_0001);
         for (int b = 1; b < 9; b++) begin
            if (b != WK_EXT_RESET) begin
               pulse(b);
            end
         end
         apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0000);
         check(32'(mode), 32'(MODE_HIB));
         apb(1'b0, ACT_TPL_ADDR, 32'h0000_0000);
         check(rd, 32'h0000_00F0);
         pulse((p == 0) ? WK_PIN_IRQ : WK_EXT_RESET);
         wait_mode(MODE_ACTIVE, 4000);
         apb(1'b0, PWR_STATUS_ADDR, 32'h0000_0000);
         check(rd, (p == 0) ? 32'h0000_0100 : 32'h0000_8000);
         check(32'(pwr_ctl.subsys_clk_en), 32'h0000_00F1);
      end
      apb(1'b1, MODE_CTRL_ADDR, 32'h0000_0002);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      check(32'(mode), 32'(MODE_ACTIVE));
      conclude();
   end

   // A hang ends the run as a failure.
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
